// File: hw/eqrs_map.vh
/*
 Constants for the egress queue ratio scheduler: register offsets, field
 positions, reset values and the scheduling period.
 Assumes it is included by its bare name from the design files.
*/
// Functional notes
// - upper enable bit set: queue in bits 14:8 limited to that many packets per period
// - lower enable bit set: queue in bits 6:0 limited to that many packets per period
// - queue 3 strict when its bit is clear: all its packets go before lower queues
// - queue 2 strict when its bit is clear: drained before any lower queue sends
// - queue 1 strict when its bit is clear: drained before queue 0 sends
// - queue 0 strict when its bit is clear: sends only after higher queues served
// - priority 3,2,1,0; queues 2,3 in first port register, 0,1 in second
// - reset limit is 4 for queue 2 and 8 for queue 3
// - reset limit is 1 for queue 0 and 2 for queue 1
// - all enable bits set after reset, so every queue starts count limited
// - ports 2 and 3 each own independent read-write settings for their egress
`ifndef EQRS_MAP_VH
`define EQRS_MAP_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define EQRS_OFS_P2_HI 8'hcc
`define EQRS_OFS_P2_LO 8'hce
`define EQRS_OFS_P3_HI 8'hd0
`define EQRS_OFS_P3_LO 8'hd2

// ************************************************************
// field positions
// ************************************************************
`define EQRS_UPR_EN 15
`define EQRS_UPR_MSB 14
`define EQRS_UPR_LSB 8
`define EQRS_LWR_EN 7
`define EQRS_LWR_MSB 6
`define EQRS_LWR_LSB 0

// ************************************************************
// reset values
// ************************************************************
`define EQRS_RST_HI 16'h8488
`define EQRS_RST_LO 16'h8182

// ************************************************************
// timing
// ************************************************************
`define EQRS_CLK_NS 8
`define EQRS_PERIOD_NS 8000
`define EQRS_PERIOD_CYC (`EQRS_PERIOD_NS / `EQRS_CLK_NS)

`endif

// File: hw/eqrs_queue_credit.v
/*
 Per-queue packet allowance counter.
 Assumes refresh and sent pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
module eqrs_queue_credit (
  // clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // configuration
  input wire i_ratio_en,
  input wire [6:0] i_limit,
  // events
  input wire i_refresh,
  input wire i_sent,
  // status
  output wire o_has_credit
);
  reg [6:0] used_ff;
  reg [6:0] nxt_used;

  // ************************************************************
  // usage count
  // ************************************************************
  // a packet sent in the refresh cycle counts against the new period
  always @* begin
    nxt_used = used_ff;
    if (i_refresh) begin
      nxt_used = {6'h00, i_sent};
    end else if (i_sent && (used_ff != 7'h7f)) begin
      nxt_used = used_ff + 7'h01; // saturate, never wrap back to credit
    end
  end

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      used_ff <= 7'h00;
    end else begin
      used_ff <= nxt_used;
    end
  end

  // strict queues always eligible; ratio queues until the limit is used
  assign o_has_credit = !i_ratio_en || (used_ff < i_limit);

endmodule // eqrs_queue_credit

// File: hw/eqrs_port_arb.v
/*
 Per-port priority picker with a registered one-hot grant.
 Assumes pending flags fall within one cycle after a grant is taken.
*/
`timescale 1ns/1ps
module eqrs_port_arb (
  // clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // queue state
  input wire [3:0] i_pend,
  input wire [3:0] i_credit,
  input wire i_tx_ready,
  // grant
  output wire [3:0] o_grant
);
  reg [3:0] grant_ff;
  reg [3:0] nxt_grant;
  wire [3:0] elig;

  assign elig = i_pend & i_credit;

  // ************************************************************
  // selection
  // ************************************************************
  // one gap cycle after each grant lets pending and credit settle
  always @* begin
    nxt_grant = 4'h0;
    if (i_tx_ready && (grant_ff == 4'h0)) begin
      if (elig[3]) begin
        nxt_grant = 4'h8;
      end else if (elig[2]) begin
        nxt_grant = 4'h4;
      end else if (elig[1]) begin
        nxt_grant = 4'h2;
      end else if (elig[0]) begin
        nxt_grant = 4'h1;
      end
    end
  end

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      grant_ff <= 4'h0;
    end else begin
      grant_ff <= nxt_grant;
    end
  end

  assign o_grant = grant_ff;

endmodule // eqrs_port_arb

// File: hw/eqrs_sched_top.v
/*
 Egress queue ratio scheduler for switch ports 2 and 3: the four weight
 registers, the scheduling period timer and one arbiter per port.
 Assumes the register strobes, pending flags and ready levels come from
 logic on i_mclk; queue logic removes a packet on each grant pulse.
*/
`timescale 1ns/1ps
`include "eqrs_map.vh"
module eqrs_sched_top (
  // clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // register access
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [1:0] i_reg_be,
  input wire [15:0] i_reg_wdata,
  output wire [15:0] o_reg_rdata,
  output wire o_reg_rvalid,
  // port 2 egress queues
  input wire [3:0] i_p2_pend,
  input wire i_p2_tx_ready,
  output wire [3:0] o_p2_grant,
  // port 3 egress queues
  input wire [3:0] i_p3_pend,
  input wire i_p3_tx_ready,
  output wire [3:0] o_p3_grant,
  // period marker
  output wire o_period_tick
);
  localparam [31:0] PERIOD_LAST_W = `EQRS_PERIOD_CYC - 1;
  localparam [9:0] PERIOD_LAST = PERIOD_LAST_W[9:0]; // period stays below 1024 cycles
  localparam [7:0] HI_ADDR2 = `EQRS_OFS_P2_HI;
  localparam [7:0] LO_ADDR2 = `EQRS_OFS_P2_LO;
  localparam [7:0] HI_ADDR3 = `EQRS_OFS_P3_HI;
  localparam [7:0] LO_ADDR3 = `EQRS_OFS_P3_LO;

  reg [15:0] p2_hi_ff;
  reg [15:0] p2_lo_ff;
  reg [15:0] p3_hi_ff;
  reg [15:0] p3_lo_ff;
  reg [15:0] rdata_ff;
  reg [15:0] nxt_rdata;
  reg rvalid_ff;
  reg [9:0] period_cnt_ff;
  reg [9:0] nxt_period_cnt;
  reg period_tick_ff;
  wire [6:0] word_addr;
  wire sel_p2_hi;
  wire sel_p2_lo;
  wire sel_p3_hi;
  wire sel_p3_lo;
  wire [3:0] p2_en;
  wire [27:0] p2_lim;
  wire [3:0] p3_en;
  wire [27:0] p3_lim;
  wire [3:0] p2_credit;
  wire [3:0] p3_credit;
  wire [3:0] p2_grant;
  wire [3:0] p3_grant;

  // ************************************************************
  // byte lane merge
  // ************************************************************
  // each strobed byte lane replaces its half of the word
  function [15:0] merge_be;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] be;
    begin
      merge_be = old_val;
      if (be[0]) begin
        merge_be[7:0] = new_val[7:0];
      end
      if (be[1]) begin
        merge_be[15:8] = new_val[15:8];
      end
    end
  endfunction

  // ************************************************************
  // address decode
  // ************************************************************
  // 16-bit registers: address bit 0 is ignored; the byte lanes come from i_reg_be
  assign word_addr = i_reg_addr[7:1];
  assign sel_p2_hi = (word_addr == HI_ADDR2[7:1]);
  assign sel_p2_lo = (word_addr == LO_ADDR2[7:1]);
  assign sel_p3_hi = (word_addr == HI_ADDR3[7:1]);
  assign sel_p3_lo = (word_addr == LO_ADDR3[7:1]);

  // ************************************************************
  // weight registers
  // ************************************************************
  // each port keeps its own pair; writes never touch the other port
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p2_hi_ff <= `EQRS_RST_HI;
      p2_lo_ff <= `EQRS_RST_LO;
      p3_hi_ff <= `EQRS_RST_HI;
      p3_lo_ff <= `EQRS_RST_LO;
    end else if (i_reg_wr) begin
      if (sel_p2_hi) begin
        p2_hi_ff <= merge_be(p2_hi_ff, i_reg_wdata, i_reg_be);
      end
      if (sel_p2_lo) begin
        p2_lo_ff <= merge_be(p2_lo_ff, i_reg_wdata, i_reg_be);
      end
      if (sel_p3_hi) begin
        p3_hi_ff <= merge_be(p3_hi_ff, i_reg_wdata, i_reg_be);
      end
      if (sel_p3_lo) begin
        p3_lo_ff <= merge_be(p3_lo_ff, i_reg_wdata, i_reg_be);
      end
    end
  end

  // ************************************************************
  // read back
  // ************************************************************
  // unmapped offsets read as zero so software sees no stale data
  always @* begin
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      if (sel_p2_hi) begin
        nxt_rdata = p2_hi_ff;
      end else if (sel_p2_lo) begin
        nxt_rdata = p2_lo_ff;
      end else if (sel_p3_hi) begin
        nxt_rdata = p3_hi_ff;
      end else if (sel_p3_lo) begin
        nxt_rdata = p3_lo_ff;
      end else begin
        nxt_rdata = 16'h0000;
      end
    end
  end

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= i_reg_rd;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;

  // ************************************************************
  // field unpacking
  // ************************************************************
  // vectors indexed by queue number, queue 3 in the top slot
  assign p2_en = {p2_hi_ff[`EQRS_LWR_EN], p2_hi_ff[`EQRS_UPR_EN],
                  p2_lo_ff[`EQRS_LWR_EN], p2_lo_ff[`EQRS_UPR_EN]};
  assign p2_lim = {p2_hi_ff[`EQRS_LWR_MSB:`EQRS_LWR_LSB], p2_hi_ff[`EQRS_UPR_MSB:`EQRS_UPR_LSB],
                   p2_lo_ff[`EQRS_LWR_MSB:`EQRS_LWR_LSB], p2_lo_ff[`EQRS_UPR_MSB:`EQRS_UPR_LSB]};
  assign p3_en = {p3_hi_ff[`EQRS_LWR_EN], p3_hi_ff[`EQRS_UPR_EN],
                  p3_lo_ff[`EQRS_LWR_EN], p3_lo_ff[`EQRS_UPR_EN]};
  assign p3_lim = {p3_hi_ff[`EQRS_LWR_MSB:`EQRS_LWR_LSB], p3_hi_ff[`EQRS_UPR_MSB:`EQRS_UPR_LSB],
                   p3_lo_ff[`EQRS_LWR_MSB:`EQRS_LWR_LSB], p3_lo_ff[`EQRS_UPR_MSB:`EQRS_UPR_LSB]};

  // ************************************************************
  // scheduling period
  // ************************************************************
  // one shared timer keeps both ports refreshed on the same edge
  always @* begin
    nxt_period_cnt = period_cnt_ff + 10'h001;
    if (period_cnt_ff == PERIOD_LAST) begin
      nxt_period_cnt = 10'h000;
    end
  end

  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      period_cnt_ff <= 10'h000;
      period_tick_ff <= 1'b0;
    end else begin
      period_cnt_ff <= nxt_period_cnt;
      period_tick_ff <= (period_cnt_ff == PERIOD_LAST);
    end
  end

  assign o_period_tick = period_tick_ff;

  // ************************************************************
  // allowance counters
  // ************************************************************
  // a limit of zero in ratio mode blocks the queue for good
  genvar q;
  generate
    for (q = 0; q < 4; q = q + 1) begin : g_queue
      eqrs_queue_credit u_p2_credit (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_ratio_en(p2_en[q]),
        .i_limit(p2_lim[7*q+6:7*q]),
        .i_refresh(period_tick_ff),
        .i_sent(p2_grant[q]),
        .o_has_credit(p2_credit[q])
      );
      eqrs_queue_credit u_p3_credit (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_ratio_en(p3_en[q]),
        .i_limit(p3_lim[7*q+6:7*q]),
        .i_refresh(period_tick_ff),
        .i_sent(p3_grant[q]),
        .o_has_credit(p3_credit[q])
      );
    end
  endgenerate

  // ************************************************************
  // per-port arbiters
  // ************************************************************
  eqrs_port_arb u_p2_arb (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_pend(i_p2_pend),
    .i_credit(p2_credit),
    .i_tx_ready(i_p2_tx_ready),
    .o_grant(p2_grant)
  );

  eqrs_port_arb u_p3_arb (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_pend(i_p3_pend),
    .i_credit(p3_credit),
    .i_tx_ready(i_p3_tx_ready),
    .o_grant(p3_grant)
  );

  // grants leave straight from the arbiter flip-flops
  assign o_p2_grant = p2_grant;
  assign o_p3_grant = p3_grant;

endmodule // eqrs_sched_top

// File: tb/eqrs_sched_checker.sv
/*
 Checker for the egress scheduler top: register answers, grant shape, period.
 Assumes it is bound to the scheduler top and that everything runs on i_mclk.
*/
`timescale 1ns/1ps
module eqrs_sched_checker (
  // clock and reset
  input wire i_mclk,
  input wire i_arst_n,
  // register side
  input wire i_reg_rd,
  input wire [15:0] o_reg_rdata,
  input wire o_reg_rvalid,
  // egress side
  input wire [3:0] i_p2_pend,
  input wire i_p2_tx_ready,
  input wire [3:0] o_p2_grant,
  input wire i_p3_tx_ready,
  input wire [3:0] o_p3_grant,
  input wire o_period_tick
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [10:0] gap_ff;
  // ************************************************************
  // cycles since last tick; zero until the first one
  // ************************************************************
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      gap_ff <= 11'h0;
    else if (o_period_tick)
      gap_ff <= 11'h1;
    else if (gap_ff != 11'h0)
      gap_ff <= gap_ff + 11'h1; // a lost tick shows as an overrun
  end
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
  a_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray answer");
  a_rdata_hold: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata)) else $error("data moved");
  a_grant_onehot: assert property ($onehot0(o_p2_grant) && $onehot0(o_p3_grant)) else $error("grant");
  a_p2_gap: assert property (|o_p2_grant |=> o_p2_grant == 4'h0) else $error("p2 no gap");
  a_p3_gap: assert property (|o_p3_grant |=> o_p3_grant == 4'h0) else $error("p3 no gap");
  a_p2_ready: assert property (|o_p2_grant |-> $past(i_p2_tx_ready)) else $error("p2 not ready");
  a_p3_ready: assert property (|o_p3_grant |-> $past(i_p3_tx_ready)) else $error("p3 not ready");
  a_grant_pending: assert property (|o_p2_grant |-> (o_p2_grant & $past(i_p2_pend)) != 4'h0)
    else $error("empty queue granted");
  a_tick_spacing: assert property (o_period_tick && gap_ff != 11'h0 |-> gap_ff == 11'h3e8)
    else $error("period length");
  a_tick_due: assert property (gap_ff <= 11'h3e8) else $error("tick missing");
  c_read: cover property (o_reg_rvalid);
  c_low_grant: cover property (o_p2_grant[0]);
  c_top_grant: cover property (o_p3_grant[3]);
  c_second_tick: cover property (o_period_tick && gap_ff != 11'h0);
endmodule // eqrs_sched_checker

// File: tb/eqrs_tb.sv
/*
 Self-checking bench for the egress scheduler; queue depths are modelled here.
 Assumes the scheduler top and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "eqrs_map.vh"
module testbench;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rdy = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [1:0] be = 2'h0;
  logic [15:0] wd = 16'h0;
  wire [15:0] rdata;
  wire rvalid;
  wire [3:0] g2;
  wire [3:0] g3;
  wire tick;
  logic [7:0] c2 [4];
  logic [7:0] c3 [4];
  logic [7:0] n2 [4];
  logic [7:0] n3 [4];
  logic [31:0] ord2;
  time t0;
  int miscompares = 0;
  int check_count = 0;
  eqrs_sched_top dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_be(be), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_p2_pend({c2[3] != 0, c2[2] != 0, c2[1] != 0, c2[0] != 0}), .i_p2_tx_ready(rdy), .o_p2_grant(g2),
    .i_p3_pend({c3[3] != 0, c3[2] != 0, c3[1] != 0, c3[0] != 0}), .i_p3_tx_ready(rdy), .o_p3_grant(g3),
    .o_period_tick(tick));
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  // ************************************************************
  // queue model: a granted packet leaves at the next edge
  // ************************************************************
  always @(posedge i_mclk) begin
    for (int q = 0; q < 4; q++) begin
      if (g2[q]) begin
        c2[q] <= c2[q] - 8'h1;
        n2[q] <= n2[q] + 8'h1;
      end
      if (g3[q]) begin
        c3[q] <= c3[q] - 8'h1;
        n3[q] <= n3[q] + 8'h1;
      end
    end
    if (|g2)
      ord2 <= {ord2[27:0], 2'h0, g2[3] | g2[2], g2[3] | g2[1]}; // grant order as nibbles
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge i_mclk);
    #1;
    wr = 1'b1;
    addr = a;
    be = b;
    wd = d;
    @(posedge i_mclk);
    #1;
    wr = 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_mclk);
    #1;
    rd = 1'b1;
    addr = a;
    @(posedge i_mclk);
    #1;
    rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk({16'h0, rdata}, {16'h0, e});
  endtask
  // fresh depths and cleared tallies
  task setup(input logic [7:0] k2, input logic [7:0] k3);
    for (int q = 0; q < 4; q++) begin
      c2[q] = k2;
      c3[q] = k3;
      n2[q] = 8'h0;
      n3[q] = 8'h0;
    end
    ord2 = 32'h0;
  endtask
  // returns one step after the edge that raised the tick
  task wait_tick;
    do begin
      @(posedge i_mclk);
      #1;
    end while (tick !== 1'b1);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    setup(8'h0, 8'h0);
    repeat (8) @(posedge i_mclk);
    #1;
    i_arst_n = 1'b1;
    rd_reg(8'hcc, 16'h8488);
    rd_reg(8'hce, 16'h8182);
    rd_reg(8'hd0, 16'h8488);
    rd_reg(8'hd2, 16'h8182);
    rd_reg(8'hd4, 16'h0000);
    wr_reg(8'hcc, 2'h1, 16'h1234);
    rd_reg(8'hcc, 16'h8434);
    rd_reg(8'hd0, 16'h8488);
    // upper lane only, odd byte address still picks the word
    wr_reg(8'hd3, 2'h2, 16'h0500);
    rd_reg(8'hd2, 16'h0582);
    rd_reg(8'hce, 16'h8182);
    wr_reg(8'hd2, 2'h2, 16'h8100);
    rd_reg(8'hd2, 16'h8182);
    // port 2 all strict: two packets per queue
    wr_reg(8'hcc, 2'h3, 16'h0000);
    wr_reg(8'hce, 2'h3, 16'h0000);
    setup(8'h2, 8'h0);
    rdy = 1'b1;
    repeat (20) @(posedge i_mclk);
    #1;
    chk(ord2[31:16], 32'h3322);
    chk(ord2[15:0], 32'h1100);
    chk({n2[3], n2[2], n2[1], n2[0]}, 32'h02020202);
    // ratio limits 2,1,1,1 on port 2, defaults on port 3
    rdy = 1'b0;
    wr_reg(8'hcc, 2'h3, 16'h8182);
    wr_reg(8'hce, 2'h3, 16'h8181);
    setup(8'h14, 8'h14);
    wait_tick;
    rdy = 1'b1;
    wait_tick;
    chk({n2[3], n2[2], n2[1], n2[0]}, 32'h02010101);
    chk({n3[3], n3[2], n3[1], n3[0]}, 32'h08040201);
    chk(ord2, 32'h00033210);
    setup(8'h14, 8'h14);
    t0 = $time;
    wait_tick;
    chk(32'(($time - t0) / `EQRS_CLK_NS), `EQRS_PERIOD_CYC);
    chk({n2[3], n2[2], n2[1], n2[0]}, 32'h02010101);
    chk({n3[3], n3[2], n3[1], n3[0]}, 32'h08040201);
    finish_test;
  end
  // the tests need about 3000 cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    miscompares++;
    finish_test;
  end
endmodule // testbench
bind eqrs_sched_top eqrs_sched_checker u_chk (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_p2_pend(i_p2_pend), .i_p2_tx_ready(i_p2_tx_ready),
  .o_p2_grant(o_p2_grant), .i_p3_tx_ready(i_p3_tx_ready), .o_p3_grant(o_p3_grant), .o_period_tick(o_period_tick));
